/* File: ilpc_pkg.sv */
// Package with register offsets, field positions, reset values and states
package ilpc_pkg;
  // Register addresses in the register file
  localparam logic [7:0] ADDR_P2_MODE    = 8'hF6;
  localparam logic [7:0] ADDR_P3_MODE    = 8'hF7;
  localparam logic [7:0] ADDR_PRIORITY   = 8'hF9;
  localparam logic [7:0] ADDR_PENDING    = 8'hFA;
  localparam logic [7:0] ADDR_MASK       = 8'hFB;
  localparam logic [7:0] ADDR_SCRATCH    = 8'hFE;
  // Field positions and values
  localparam int         NUM_SRC         = 6;
  localparam logic [7:0] PENDING_USED    = 8'h3F;
  localparam logic [7:0] SCRATCH_RESET   = 8'h00;
  localparam logic [7:0] MODE_RESET      = 8'h00;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam int         RECOVERY_BIT    = 7;
  localparam logic [15:0] STOP_RESUME_PC = 16'h000C;
  // Low-power states
  typedef enum logic [1:0] {
    ILPC_RUN  = 2'b00,
    ILPC_HALT = 2'b01,
    ILPC_STOP = 2'b10
  } ilpc_power_t;
endpackage

/* File: ilpc_edge_det.sv */
// Synchroniser with edge detector for one port input line
module ilpc_edge_det (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Two-stage synchroniser, then one-sample history for the compare
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Only consecutive clean samples are compared, so a held level gives one event
  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~prev_reg;
  assign fall_o  = ~sync_reg & prev_reg;
endmodule

/* File: ilpc_top.sv */
// Interrupt sourcing, prioritising and HALT/STOP control block
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Three fixed input lines feed four edge sources and the timer input.
// - Sources a,b,c fall on bits 2,3,1; d rises on bit 2; even vectors 0..10.
// - Pending requests pass mask and global enable, then priority picks a vector.
// - Pending register holds sources in bits 0-5; bits 7-6 read zero.
// - HALT gates the processor clock; oscillator keeps running.
// - Timer and external edge sources stay active while halted.
// - HALT ends only when an enabled interrupt request is pending.
// - After halt service, execution resumes after the HALT instruction.
// - Watchdog timeout while halted gives a full normal reset.
// - STOP turns off both internal clock and oscillator.
// - Low recovery pin releases STOP by reset; fetch starts at 000C.
// - Pin recovery keeps port mode registers at their pre-stop values.
// - General-purpose registers keep their values across any reset.
// - Scratch byte clears to zero on every reset and stop recovery.
module ilpc_top (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       input_bit_one_i,
  input  wire logic       input_bit_two_i,
  input  wire logic       input_bit_three_i,
  input  wire logic       stop_recovery_pin_i,
  input  wire logic       timer_source_i,
  input  wire logic       watchdog_timeout_i,
  input  wire logic       global_enable_i,
  input  wire logic       halt_exec_i,
  input  wire logic       stop_exec_i,
  input  wire logic       vector_ack_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            irq_req_o,
  output logic      [3:0] vector_o,
  output logic            cpu_clk_en_o,
  output logic            osc_en_o,
  output logic            full_reset_o,
  output logic            stop_recover_o,
  output logic            resume_after_halt_o,
  output logic            timer_input_signal_o,
  output logic      [7:0] port2_mode_o,
  output logic      [7:0] port3_mode_o
);
  //////////////////////////////////////////////////////////////////////////
  logic [7:0]             port2_direction_mode_reg;
  logic [7:0]             port3_input_mode_reg;
  logic [7:0]             interrupt_priority_reg;
  logic [5:0]             interrupt_pending_reg;
  logic [5:0]             interrupt_pending_next;
  logic [5:0]             interrupt_mask_reg;
  logic [7:0]             scratch_byte_reg;
  logic [7:0]             rdata_reg;
  logic                   irq_reg;
  logic [3:0]             vector_reg;
  logic [2:0]             vec_idx_reg;
  logic                   cpu_clk_reg;
  logic                   osc_reg;
  logic                   full_rst_reg;
  logic                   recover_reg;
  logic                   resume_reg;
  logic                   tin_reg;
  logic                   halted_wake_reg;
  ilpc_pkg::ilpc_power_t  power_reg;
  ilpc_pkg::ilpc_power_t  power_next;
  logic                   rec_meta_reg;
  logic                   rec_sync_reg;
  logic                   tmr_meta_reg;
  logic                   tmr_sync_reg;
  logic                   tmr_prev_reg;
  logic                   b1_fall;
  logic                   b2_rise;
  logic                   b2_fall;
  logic                   b3_lvl;
  logic                   b3_fall;

  //////////////////////////////////////////////////////////////////////////
  // One synchroniser per fixed input line
  ilpc_edge_det u_bit_one (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (input_bit_one_i),
    .level_o   (),
    .rise_o    (),
    .fall_o    (b1_fall)
  );
  ilpc_edge_det u_bit_two (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (input_bit_two_i),
    .level_o   (),
    .rise_o    (b2_rise),
    .fall_o    (b2_fall)
  );
  ilpc_edge_det u_bit_three (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (input_bit_three_i),
    .level_o   (b3_lvl),
    .rise_o    (),
    .fall_o    (b3_fall)
  );

  //////////////////////////////////////////////////////////////////////////
  // Decode and source events
  logic [5:0] src_event;
  logic       tmr_event;
  logic       wr_p2;
  logic       wr_p3;
  logic       wr_prio;
  logic       wr_pend;
  logic       wr_mask;
  logic       wr_scr;
  logic       sw_set;
  logic [5:0] sw_clr;
  logic [5:0] ack_clr;
  logic [5:0] enabled_req;
  logic       any_enabled;
  logic [2:0] win_idx;
  logic [7:0] rdata_mux;
  logic       recover_low;

  assign tmr_event   = tmr_sync_reg & ~tmr_prev_reg;
  assign src_event   = {tmr_event, 1'b0, b2_rise, b1_fall, b3_fall, b2_fall};
  assign wr_p2       = reg_wr_i & (reg_addr_i == ilpc_pkg::ADDR_P2_MODE);
  assign wr_p3       = reg_wr_i & (reg_addr_i == ilpc_pkg::ADDR_P3_MODE);
  assign wr_prio     = reg_wr_i & (reg_addr_i == ilpc_pkg::ADDR_PRIORITY);
  assign wr_pend     = reg_wr_i & (reg_addr_i == ilpc_pkg::ADDR_PENDING);
  assign wr_mask     = reg_wr_i & (reg_addr_i == ilpc_pkg::ADDR_MASK);
  assign wr_scr      = reg_wr_i & (reg_addr_i == ilpc_pkg::ADDR_SCRATCH);
  // Software source is raised by writing a one into its pending bit
  assign sw_set      = wr_pend & reg_wdata_i[4];
  assign sw_clr      = wr_pend ? ~reg_wdata_i[5:0] : 6'h00;
  assign ack_clr     = (vector_ack_i & irq_reg) ?
                       6'(6'h01 << vec_idx_reg) : 6'h00;
  assign enabled_req = interrupt_pending_reg & interrupt_mask_reg &
                       {6{global_enable_i}};
  assign any_enabled = |enabled_req;
  assign recover_low = (power_reg == ilpc_pkg::ILPC_STOP) & ~rec_sync_reg;

  // Fixed priority, lowest source number first; priority register is kept for software
  always_comb begin
    win_idx = 3'h0;
    for (int i = ilpc_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (enabled_req[i]) begin
        win_idx = 3'(i);
      end
    end
  end

  // Events win over a clear arriving in the same cycle
  assign interrupt_pending_next = ((interrupt_pending_reg & ~sw_clr & ~ack_clr) |
                                   src_event | {1'b0, sw_set, 4'h0});

  // Read multiplexer; reserved pending bits read zero
  assign rdata_mux = (reg_addr_i == ilpc_pkg::ADDR_P2_MODE)  ? port2_direction_mode_reg :
                     (reg_addr_i == ilpc_pkg::ADDR_P3_MODE)  ? port3_input_mode_reg :
                     (reg_addr_i == ilpc_pkg::ADDR_PRIORITY) ? interrupt_priority_reg :
                     (reg_addr_i == ilpc_pkg::ADDR_PENDING)  ?
                       {2'b00, interrupt_pending_reg} :
                     (reg_addr_i == ilpc_pkg::ADDR_MASK)     ?
                       {2'b00, interrupt_mask_reg} :
                     (reg_addr_i == ilpc_pkg::ADDR_SCRATCH)  ? scratch_byte_reg :
                     ilpc_pkg::ZERO_BYTE;

  // Power state sequencing
  always_comb begin
    power_next = power_reg;
    unique case (power_reg)
      ilpc_pkg::ILPC_RUN: begin
        if (stop_exec_i) begin
          power_next = ilpc_pkg::ILPC_STOP;
        end else if (halt_exec_i) begin
          power_next = ilpc_pkg::ILPC_HALT;
        end
      end
      ilpc_pkg::ILPC_HALT: begin
        if (any_enabled) begin
          power_next = ilpc_pkg::ILPC_RUN;
        end
      end
      ilpc_pkg::ILPC_STOP: begin
        if (~rec_sync_reg) begin
          power_next = ilpc_pkg::ILPC_RUN;
        end
      end
      default: power_next = ilpc_pkg::ILPC_RUN;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Recovery pin and timer input synchronisers
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rec_meta_reg <= 1'b1;
      rec_sync_reg <= 1'b1;
      tmr_meta_reg <= 1'b0;
      tmr_sync_reg <= 1'b0;
      tmr_prev_reg <= 1'b0;
    end else begin
      rec_meta_reg <= stop_recovery_pin_i;
      rec_sync_reg <= rec_meta_reg;
      tmr_meta_reg <= timer_source_i;
      tmr_sync_reg <= tmr_meta_reg;
      tmr_prev_reg <= tmr_sync_reg;
    end
  end

  // Interrupt registers; mode registers survive a stop recovery as it is no reset here
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port2_direction_mode_reg <= ilpc_pkg::MODE_RESET;
      port3_input_mode_reg     <= ilpc_pkg::MODE_RESET;
      interrupt_priority_reg   <= ilpc_pkg::ZERO_BYTE;
      interrupt_pending_reg    <= 6'h00;
      interrupt_mask_reg       <= 6'h00;
    end else begin
      if (wr_p2) port2_direction_mode_reg <= reg_wdata_i;
      if (wr_p3) port3_input_mode_reg <= reg_wdata_i;
      if (wr_prio) interrupt_priority_reg <= reg_wdata_i;
      if (wr_mask) interrupt_mask_reg <= reg_wdata_i[5:0];
      interrupt_pending_reg <= interrupt_pending_next;
    end
  end

  // Scratch byte: cleared by reset and by pin recovery
  // General-purpose file sits outside and sees no reset from here
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scratch_byte_reg <= ilpc_pkg::SCRATCH_RESET;
    end else if (recover_low) begin
      scratch_byte_reg <= ilpc_pkg::SCRATCH_RESET;
    end else if (wr_scr) begin
      scratch_byte_reg <= reg_wdata_i;
    end
  end

  // Vector request and power outputs
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_reg       <= ilpc_pkg::ILPC_RUN;
      irq_reg         <= 1'b0;
      vector_reg      <= 4'h0;
      vec_idx_reg     <= 3'h0;
      cpu_clk_reg     <= 1'b1;
      osc_reg         <= 1'b1;
      full_rst_reg    <= 1'b0;
      recover_reg     <= 1'b0;
      resume_reg      <= 1'b0;
      halted_wake_reg <= 1'b0;
      tin_reg         <= 1'b0;
      rdata_reg       <= ilpc_pkg::ZERO_BYTE;
    end else begin
      power_reg    <= power_next;
      irq_reg      <= any_enabled & ~(vector_ack_i & irq_reg);
      vec_idx_reg  <= win_idx;
      vector_reg   <= {win_idx, 1'b0};
      cpu_clk_reg  <= (power_next == ilpc_pkg::ILPC_RUN);
      osc_reg      <= (power_next != ilpc_pkg::ILPC_STOP);
      // Watchdog gives the same full reset whatever the state
      full_rst_reg <= watchdog_timeout_i;
      recover_reg  <= recover_low;
      if (power_reg == ilpc_pkg::ILPC_HALT && any_enabled) begin
        halted_wake_reg <= 1'b1;
      end else if (vector_ack_i & irq_reg) begin
        halted_wake_reg <= 1'b0;
      end
      resume_reg   <= halted_wake_reg & vector_ack_i & irq_reg;
      tin_reg      <= b3_lvl;
      rdata_reg    <= rdata_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign reg_rdata_o          = rdata_reg;
  assign irq_req_o            = irq_reg;
  assign vector_o             = vector_reg;
  assign cpu_clk_en_o         = cpu_clk_reg;
  assign osc_en_o             = osc_reg;
  assign full_reset_o         = full_rst_reg;
  assign stop_recover_o       = recover_reg;
  assign resume_after_halt_o  = resume_reg;
  assign timer_input_signal_o = tin_reg;
  assign port2_mode_o         = port2_direction_mode_reg;
  assign port3_mode_o         = port3_input_mode_reg;

  //////////////////////////////////////////////////////////////////////////
  a_halt_no_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (power_reg == ilpc_pkg::ILPC_HALT && !any_enabled) |=> power_reg != ilpc_pkg::ILPC_RUN)
    else $error("halt left without enabled request");
  a_halt_clk_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (power_reg == ilpc_pkg::ILPC_HALT) |-> !cpu_clk_en_o && osc_en_o)
    else $error("halt clock gating wrong");
  a_stop_osc_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (power_reg == ilpc_pkg::ILPC_STOP) |-> !osc_en_o && !cpu_clk_en_o)
    else $error("stop leaves oscillator on");
  a_edge_sets_pend: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    b2_fall |=> interrupt_pending_reg[0])
    else $error("falling edge did not set pending");
  a_mask_gates_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (interrupt_mask_reg == 6'h00) |=> !irq_req_o)
    else $error("masked request raised");
  a_recover_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    recover_low |=> scratch_byte_reg == ilpc_pkg::SCRATCH_RESET && stop_recover_o)
    else $error("recovery did not clear scratch");
  a_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(reg_addr_i) == ilpc_pkg::ADDR_PENDING |-> reg_rdata_o[7:6] == 2'b00)
    else $error("reserved pending bits nonzero");
  a_modes_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (recover_low && !wr_p2) |=> $stable(port2_direction_mode_reg))
    else $error("mode lost on recovery");
  a_wdt_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    watchdog_timeout_i |=> full_reset_o)
    else $error("watchdog reset missing");
endmodule

/* File: ilpc_cpu_model.sv */
// Behavioural CPU core that takes the vectors the block presents
module ilpc_cpu_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       take_en_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       irq_req_i,
  output logic            vector_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_reg;
  // One-cycle ack; a cycle off after each, so a stale request is never taken
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_reg     <= 4'h0;
      vector_ack_o <= 1'b0;
    end else if (vector_ack_o || !irq_req_i || !take_en_i) begin
      wait_reg     <= 4'h0;
      vector_ack_o <= 1'b0;
    end else if (wait_reg >= delay_i) begin
      vector_ack_o <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

/* File: ilpc_bench.sv */
// Self-checking bench for the interrupt and low-power control block
module ilpc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic [3:1] pins = 3'b111;
  logic       recover_pin_b = 1'b1;
  logic       timer_src = 1'b0, wdog = 1'b0, gen = 1'b0, halt_x = 1'b0;
  logic       stop_x = 1'b0, wr_s = 1'b0, take_en = 1'b0, ack;
  logic [3:0] delay = 4'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, p2m, p3m, w;
  logic       irq_req, clk_en, osc_en, full_rst, stop_rec, resume, timer_input_signal;
  logic [3:0] vec;
  logic [31:0] lfsr = 32'hC236;
  logic       seen_resume = 1'b0, seen_full = 1'b0, seen_rec = 1'b0;
  int         exp_pend = 0, mask = 0, idx, n_fail = 0, n_compared = 0;
  logic [7:0] addrs [6] = '{ilpc_pkg::ADDR_P2_MODE, ilpc_pkg::ADDR_P3_MODE,
    ilpc_pkg::ADDR_PRIORITY, ilpc_pkg::ADDR_PENDING, ilpc_pkg::ADDR_MASK,
    ilpc_pkg::ADDR_SCRATCH};

  ilpc_top uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .input_bit_one_i(pins[1]),
    .input_bit_two_i(pins[2]), .input_bit_three_i(pins[3]),
    .stop_recovery_pin_i(recover_pin_b), .timer_source_i(timer_src),
    .watchdog_timeout_i(wdog), .global_enable_i(gen), .halt_exec_i(halt_x),
    .stop_exec_i(stop_x), .vector_ack_i(ack), .reg_wr_i(wr_s), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .irq_req_o(irq_req), .vector_o(vec),
    .cpu_clk_en_o(clk_en), .osc_en_o(osc_en), .full_reset_o(full_rst),
    .stop_recover_o(stop_rec), .resume_after_halt_o(resume),
    .timer_input_signal_o(timer_input_signal), .port2_mode_o(p2m), .port3_mode_o(p3m));
  ilpc_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .take_en_i(take_en),
    .delay_i(delay), .irq_req_i(irq_req), .vector_ack_o(ack));

  always #2.5 clk_sys_i = ~clk_sys_i;

  //////////////////////////////////////////////////////////////////////////////
  // Reference choice of vector at every accepted ack; sticky pulse catchers
  always @(posedge clk_sys_i) begin
    if (rst_b_i && ack && irq_req) begin
      idx = 0;
      while (idx < 5 && (((exp_pend & mask) >> idx) & 1) == 0) idx++;
      chk({4'h0, vec}, 8'(2 * idx));
      exp_pend &= ~(1 << idx);
    end
    if (resume) seen_resume = 1'b1;
    if (full_rst) seen_full = 1'b1;
    if (stop_rec) seen_rec = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr_s <= 1'b0;
  endtask
  // Read data lands one edge after the address is shown
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr <= a;
    @(posedge clk_sys_i);
    #1 chk(rdata, e);
  endtask
  // Held levels must give a single event, so six cycles of settle time
  task automatic pins_to(input logic [3:1] v, input int src);
    @(posedge clk_sys_i);
    pins <= v;
    tick(6);
    if (src >= 0) exp_pend |= 1 << src;
  endtask
  task automatic low_power(input bit stop);
    @(posedge clk_sys_i);
    if (stop) stop_x <= 1'b1;
    else halt_x <= 1'b1;
    @(posedge clk_sys_i);
    stop_x <= 1'b0;
    halt_x <= 1'b0;
    tick(2);
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    tick(20000);
    n_fail++;
    $display("ERROR at %0t: run hung", $time);
    results;
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(8);
    rst_b_i <= 1'b1;
    tick(2);
    // Reset contents, an unmapped place, random bytes through each place but the pending one
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    rd(8'h40, 8'h00);
    chk({6'h0, clk_en, osc_en}, 8'h03);
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      if (i != 3) wr(addrs[i], lfsr[7:0]);
      if (i != 3) rd(addrs[i], (i == 4) ? (lfsr[7:0] & ilpc_pkg::PENDING_USED) : lfsr[7:0]);
      if (i == 0) chk(p2m, lfsr[7:0]);
      if (i == 1) chk(p3m, lfsr[7:0]);
    end
    wr(ilpc_pkg::ADDR_PENDING, 8'hD0);
    rd(ilpc_pkg::ADDR_PENDING, 8'h10);
    wr(ilpc_pkg::ADDR_PENDING, 8'h00);
    rd(ilpc_pkg::ADDR_PENDING, 8'h00);
    // Every source latched while requests are globally off
    wr(ilpc_pkg::ADDR_MASK, 8'h3F);
    mask = 63;
    pins_to(3'b101, 0);
    pins_to(3'b111, 3);
    pins_to(3'b011, 1);
    chk({7'h0, timer_input_signal}, 8'h00);
    pins_to(3'b010, 2);
    pins_to(3'b111, -1);
    chk({7'h0, timer_input_signal}, 8'h01);
    @(posedge clk_sys_i);
    timer_src <= 1'b1;
    tick(6);
    timer_src <= 1'b0;
    exp_pend |= 32;
    wr(ilpc_pkg::ADDR_PENDING, 8'(exp_pend | 16));
    exp_pend |= 16;
    rd(ilpc_pkg::ADDR_PENDING, 8'h3F);
    chk({7'h0, irq_req}, 8'h00);
    // Mask gate, then all six taken in priority order at random pace
    wr(ilpc_pkg::ADDR_MASK, 8'h00);
    mask = 0;
    gen <= 1'b1;
    tick(4);
    chk({7'h0, irq_req}, 8'h00);
    lfsr = nxt(lfsr);
    delay <= lfsr[3:0];
    take_en <= 1'b1;
    wr(ilpc_pkg::ADDR_MASK, 8'h3F);
    mask = 63;
    for (int i = 0; i < 300 && exp_pend != 0; i++) tick(1);
    tick(4);
    rd(ilpc_pkg::ADDR_PENDING, 8'h00);
    // HALT: masked requests keep it asleep, a serviced one wakes it
    take_en <= 1'b0;
    wr(ilpc_pkg::ADDR_MASK, 8'h00);
    mask = 0;
    low_power(1'b0);
    chk({6'h0, clk_en, osc_en}, 8'h01);
    pins_to(3'b101, 0);
    pins_to(3'b111, 3);
    rd(ilpc_pkg::ADDR_PENDING, 8'h09);
    chk({7'h0, clk_en}, 8'h00);
    seen_resume = 1'b0;
    take_en <= 1'b1;
    wr(ilpc_pkg::ADDR_MASK, 8'h08);
    mask = 8;
    tick(30);
    chk({6'h0, seen_resume, clk_en}, 8'h03);
    rd(ilpc_pkg::ADDR_PENDING, 8'h01);
    // Watchdog while halted gives the full reset
    take_en <= 1'b0;
    low_power(1'b0);
    seen_full = 1'b0;
    @(posedge clk_sys_i);
    wdog <= 1'b1;
    @(posedge clk_sys_i);
    wdog <= 1'b0;
    tick(2);
    chk({7'h0, seen_full}, 8'h01);
    rst_b_i <= 1'b0;
    tick(8);
    rst_b_i <= 1'b1;
    exp_pend = 0;
    tick(2);
    rd(ilpc_pkg::ADDR_PENDING, 8'h00);
    chk({6'h0, clk_en, osc_en}, 8'h03);
    // STOP and pin recovery: mode kept, scratch cleared
    lfsr = nxt(lfsr);
    w = lfsr[7:0] | 8'h80;
    wr(ilpc_pkg::ADDR_P2_MODE, w);
    wr(ilpc_pkg::ADDR_SCRATCH, 8'h5A);
    tick(1);
    low_power(1'b1);
    chk({6'h0, clk_en, osc_en}, 8'h00);
    seen_rec = 1'b0;
    recover_pin_b <= 1'b0;
    tick(6);
    recover_pin_b <= 1'b1;
    tick(3);
    chk({5'h0, seen_rec, clk_en, osc_en}, 8'h07);
    rd(ilpc_pkg::ADDR_SCRATCH, 8'h00);
    rd(ilpc_pkg::ADDR_P2_MODE, w);
    chk(p2m, w);
    results;
  end
endmodule
